/* pkg/pdt_pkg.sv */
package pdt_pkg;

    // ************************************************************
    // register map on the wishbone slave
    // ************************************************************
    localparam logic [7:0]  PDT_OFS_READ_PAGE  = 8'h00;
    localparam logic [7:0]  PDT_OFS_WRITE_PAGE = 8'h04;
    localparam logic [7:0]  PDT_OFS_TABLE_PAGE = 8'h08;
    localparam logic [7:0]  PDT_OFS_LAST_ADDR  = 8'h0C;

    // ************************************************************
    // widths, field positions and reset values
    // ************************************************************
    localparam int          PDT_RPAGE_W        = 10;
    localparam int          PDT_WPAGE_W        = 9;
    localparam int          PDT_TPAGE_W        = 8;
    localparam int          PDT_RPAGE_PSV_BIT  = 9;
    localparam int          PDT_EA_PAGE_BIT    = 15;
    localparam int          PDT_TPAGE_CFG_BIT  = 7;
    localparam int          PDT_LAST_BUSY_BIT  = 31;
    localparam logic [9:0]  PDT_RPAGE_RESET    = 10'h000;
    localparam logic [8:0]  PDT_WPAGE_RESET    = 9'h000;
    localparam logic [7:0]  PDT_TPAGE_RESET    = 8'h00;
    localparam logic [15:0] PDT_WORD_STEP      = 16'h0002;
    localparam logic [15:0] PDT_BYTE_STEP      = 16'h0001;

    // ************************************************************
    // operations from the core
    // ************************************************************
    typedef enum logic [2:0] {
        PDT_OP_DATA_READ        = 3'b000,
        PDT_OP_DATA_WRITE       = 3'b001,
        PDT_OP_TABLE_READ_LOW   = 3'b010,
        PDT_OP_TABLE_READ_HIGH  = 3'b011,
        PDT_OP_TABLE_WRITE_LOW  = 3'b100,
        PDT_OP_TABLE_WRITE_HIGH = 3'b101
    } pdt_op_e;

    typedef enum logic [1:0] {
        PDT_ST_IDLE = 2'b00,
        PDT_ST_DATA = 2'b01,
        PDT_ST_PROG = 2'b10
    } pdt_state_e;

endpackage : pdt_pkg

/* rtl/pdt_table_steer.sv */
`timescale 1ns/1ps

// ************************************************************
// table read steering: program word to 16-bit data result
// ************************************************************
module pdt_table_steer
    import pdt_pkg::*;
(
    input  wire logic        i_high,     // high part selected
    input  wire logic        i_byte,     // byte mode
    input  wire logic        i_bsel,     // byte select
    input  wire logic [23:0] i_word,     // program word
    output logic      [15:0] o_data      // steered data
);

    wire logic [7:0] lo_byte;
    wire logic [7:0] hi_sel;

    // low word byte pick, upper byte on select one
    assign lo_byte = i_bsel ? i_word[15:8] : i_word[7:0];
    // phantom byte above bit 23 always reads zero
    assign hi_sel  = i_bsel ? 8'h00 : i_word[23:16];

    assign o_data = !i_high ? (i_byte ? {8'h00, lo_byte}
                                      : i_word[15:0])
                            : (i_byte ? {8'h00, hi_sel}
                                      : {8'h00, i_word[23:16]});

endmodule : pdt_table_steer

/* rtl/pdt_paged_access.sv */
`timescale 1ns/1ps

// Contract
// - hold 10-bit read page and separate 9-bit write page registers
// - read page bit9 clear, ea15 set: read address is page 8..0 over ea
// - ea15 set on write: write address is write page 8..0 over ea
// - both page registers are readable and writable by software
// - program address advances by two per 24-bit program word
// - program memory is low word space beside high byte space
// - word low table read returns program bits 15..0
// - byte low table read: select one takes upper byte, else lower
// - word high table read returns bits 23..16, upper data byte zero
// - byte high table read returns selected byte, phantom byte zero
// - high table operations are the only path to program bits 23..16
// - every table access takes its region from the table page
// - table page bit7 clear selects user space, set configuration
// - low table accesses reach program space directly, no data window
module pdt_paged_access
    import pdt_pkg::*;
(
    input  wire logic        i_clock,        // 125 MHz system clock
    input  wire logic        i_reset,        // async reset, active high
    // wishbone slave
    input  wire logic        i_wb_cyc,       // bus cycle
    input  wire logic        i_wb_stb,       // strobe
    input  wire logic        i_wb_we,        // write enable
    input  wire logic [7:0]  i_wb_adr,       // byte address
    input  wire logic [3:0]  i_wb_sel,       // byte enables
    input  wire logic [31:0] i_wb_dat,       // write data
    output logic      [31:0] o_wb_dat,       // read data
    output logic             o_wb_ack,       // acknowledge
    // core request port
    input  wire logic        i_req_valid,    // request pulse
    input  wire logic [2:0]  i_req_op,       // pdt_op_e code
    input  wire logic        i_req_byte,     // byte mode
    input  wire logic [15:0] i_req_ea,       // effective address
    input  wire logic [15:0] i_req_wdata,    // write data
    output logic             o_req_busy,     // request in flight
    output logic             o_req_done,     // completion pulse
    output logic      [15:0] o_req_rdata,    // read result
    output logic      [15:0] o_req_next_ea,  // post-step address
    // extended data memory
    output logic             o_dm_req,       // access request
    output logic             o_dm_we,        // write
    output logic      [23:0] o_dm_addr,      // 24-bit data address
    output logic      [15:0] o_dm_wdata,     // write data
    output logic      [1:0]  o_dm_be,        // byte enables
    input  wire logic        i_dm_ack,       // access done
    input  wire logic [15:0] i_dm_rdata,     // read data
    // program memory
    output logic             o_pm_req,       // access request
    output logic             o_pm_we,        // write
    output logic      [23:0] o_pm_addr,      // program address
    output logic             o_pm_cfg,       // configuration space
    output logic      [23:0] o_pm_wdata,     // write word
    output logic      [2:0]  o_pm_be,        // byte enables
    input  wire logic        i_pm_ack,       // access done
    input  wire logic [23:0] i_pm_rdata      // read word
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [9:0]   read_page_reg;
    logic [8:0]   write_page_reg;
    logic [7:0]   table_page_reg;
    logic [23:0]  last_addr_reg;
    pdt_state_e   state_reg;
    pdt_op_e      op_reg;
    logic         byte_reg;
    logic         bsel_reg;
    logic         psv_reg;

    // byte enable pair from mode and select
    function automatic logic [1:0] pdt_be2(input logic b, input logic s);
        pdt_be2 = !b ? 2'b11 : (s ? 2'b10 : 2'b01);
    endfunction : pdt_be2

    // ************************************************************
    // wishbone decode
    // ************************************************************
    wire logic        wb_hit;
    wire logic        wb_wr;
    wire logic        sel_rp;
    wire logic        sel_wp;
    wire logic        sel_tp;
    wire logic        sel_la;
    wire logic [31:0] wb_rd;

    assign wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wb_wr  = wb_hit & i_wb_we;
    assign sel_rp = (i_wb_adr == PDT_OFS_READ_PAGE);
    assign sel_wp = (i_wb_adr == PDT_OFS_WRITE_PAGE);
    assign sel_tp = (i_wb_adr == PDT_OFS_TABLE_PAGE);
    assign sel_la = (i_wb_adr == PDT_OFS_LAST_ADDR);
    // unmapped addresses are acked and read as zero
    assign wb_rd  = sel_rp ? {22'h0, read_page_reg}
                  : sel_wp ? {23'h0, write_page_reg}
                  : sel_tp ? {24'h0, table_page_reg}
                  : sel_la ? {(state_reg != PDT_ST_IDLE), 7'h00,
                              last_addr_reg}
                  : 32'h0;

    // ************************************************************
    // request decode and address forming
    // ************************************************************
    wire pdt_op_e     req_op;
    wire logic        req_go;
    wire logic        ea_paged;
    wire logic        is_table;
    wire logic        is_high;
    wire logic        is_write;
    wire logic        is_psv;
    wire logic [23:0] rd_addr;
    wire logic [23:0] wr_addr;
    wire logic [23:0] psv_addr;
    wire logic [23:0] tbl_addr;
    wire logic [1:0]  be_pair;
    wire logic [15:0] steered;

    assign req_op   = pdt_op_e'(i_req_op);
    assign req_go   = i_req_valid & (state_reg == PDT_ST_IDLE);
    assign ea_paged = i_req_ea[PDT_EA_PAGE_BIT];
    assign is_table = (req_op != PDT_OP_DATA_READ)
                    & (req_op != PDT_OP_DATA_WRITE);
    assign is_high  = (req_op == PDT_OP_TABLE_READ_HIGH)
                    | (req_op == PDT_OP_TABLE_WRITE_HIGH);
    assign is_write = (req_op == PDT_OP_DATA_WRITE)
                    | (req_op == PDT_OP_TABLE_WRITE_LOW)
                    | (req_op == PDT_OP_TABLE_WRITE_HIGH);
    assign is_psv   = (req_op == PDT_OP_DATA_READ) & ea_paged
                    & read_page_reg[PDT_RPAGE_PSV_BIT];
    // base space below ea15, pages only above it
    assign rd_addr  = ea_paged ? {read_page_reg[8:0], i_req_ea[14:0]}
                               : {8'h00, i_req_ea};
    assign wr_addr  = ea_paged ? {write_page_reg, i_req_ea[14:0]}
                               : {8'h00, i_req_ea};
    // psv window: page bits 7..0 over ea, word aligned program address
    assign psv_addr = {read_page_reg[7:0], i_req_ea[14:0], 1'b0};
    // table address is table page over the even word address,
    // so successive program words sit two apart
    assign tbl_addr = {table_page_reg, i_req_ea[15:1], 1'b0};
    assign be_pair  = pdt_be2(i_req_byte, i_req_ea[0]);

    pdt_table_steer u_steer (
        .i_high (op_reg == PDT_OP_TABLE_READ_HIGH),
        .i_byte (byte_reg),
        .i_bsel (bsel_reg),
        .i_word (i_pm_rdata),
        .o_data (steered)
    );

    // ************************************************************
    // wishbone registers
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            read_page_reg  <= PDT_RPAGE_RESET;
            write_page_reg <= PDT_WPAGE_RESET;
            table_page_reg <= PDT_TPAGE_RESET;
            o_wb_ack       <= 1'b0;
            o_wb_dat       <= 32'h0;
        end else begin
            o_wb_ack <= wb_hit;
            o_wb_dat <= wb_hit ? wb_rd : 32'h0;
            if (wb_wr && sel_rp) begin
                if (i_wb_sel[0]) read_page_reg[7:0] <= i_wb_dat[7:0];
                if (i_wb_sel[1]) read_page_reg[9:8] <= i_wb_dat[9:8];
            end
            if (wb_wr && sel_wp) begin
                if (i_wb_sel[0]) write_page_reg[7:0] <= i_wb_dat[7:0];
                if (i_wb_sel[1]) write_page_reg[8] <= i_wb_dat[8];
            end
            if (wb_wr && sel_tp && i_wb_sel[0]) begin
                table_page_reg <= i_wb_dat[7:0];
            end
        end
    end

    // ************************************************************
    // access sequencer
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_reg     <= PDT_ST_IDLE;
            op_reg        <= PDT_OP_DATA_READ;
            byte_reg      <= 1'b0;
            bsel_reg      <= 1'b0;
            psv_reg       <= 1'b0;
            last_addr_reg <= 24'h0;
            o_req_busy    <= 1'b0;
            o_req_done    <= 1'b0;
            o_req_rdata   <= 16'h0;
            o_req_next_ea <= 16'h0;
            o_dm_req      <= 1'b0;
            o_dm_we       <= 1'b0;
            o_dm_addr     <= 24'h0;
            o_dm_wdata    <= 16'h0;
            o_dm_be       <= 2'b00;
            o_pm_req      <= 1'b0;
            o_pm_we       <= 1'b0;
            o_pm_addr     <= 24'h0;
            o_pm_cfg      <= 1'b0;
            o_pm_wdata    <= 24'h0;
            o_pm_be       <= 3'b000;
        end else begin
            o_req_done <= 1'b0;
            case (state_reg)
                PDT_ST_IDLE: begin
                    if (req_go) begin
                        op_reg        <= req_op;
                        byte_reg      <= i_req_byte;
                        bsel_reg      <= i_req_ea[0];
                        psv_reg       <= is_psv;
                        o_req_busy    <= 1'b1;
                        // byte steps by one, words by two
                        o_req_next_ea <= i_req_ea + (i_req_byte ?
                            PDT_BYTE_STEP : PDT_WORD_STEP);
                        if (is_table || is_psv) begin
                            // program path, direct for table ops, through the data window for psv
                            state_reg  <= PDT_ST_PROG;
                            o_pm_req   <= 1'b1;
                            o_pm_we    <= is_write;
                            o_pm_addr  <= is_psv ? psv_addr : tbl_addr;
                            last_addr_reg <= is_psv ? psv_addr
                                                    : tbl_addr;
                            o_pm_cfg   <= !is_psv &&
                                table_page_reg[PDT_TPAGE_CFG_BIT];
                            // high ops alone reach bits 23..16
                            o_pm_wdata <= is_high
                                ? {i_req_wdata[7:0], 16'h0000}
                                : {8'h00, i_req_byte
                                   ? {2{i_req_wdata[7:0]}}
                                   : i_req_wdata};
                            // low word space vs high byte space
                            o_pm_be    <= is_psv ? 3'b011
                                : !is_high ? {1'b0, be_pair}
                                : (i_req_byte && i_req_ea[0])
                                  ? 3'b000 : 3'b100;
                        end else begin
                            state_reg  <= PDT_ST_DATA;
                            o_dm_req   <= 1'b1;
                            o_dm_we    <= is_write;
                            // unpaged when ea15 is clear
                            o_dm_addr  <= is_write ? wr_addr
                                                   : rd_addr;
                            last_addr_reg <= is_write ? wr_addr
                                                      : rd_addr;
                            o_dm_wdata <= i_req_byte
                                ? {2{i_req_wdata[7:0]}} : i_req_wdata;
                            o_dm_be    <= be_pair;
                        end
                    end
                end
                PDT_ST_DATA: begin
                    if (i_dm_ack) begin
                        state_reg   <= PDT_ST_IDLE;
                        o_dm_req    <= 1'b0;
                        o_dm_we     <= 1'b0;
                        o_req_busy  <= 1'b0;
                        o_req_done  <= 1'b1;
                        o_req_rdata <= !byte_reg ? i_dm_rdata
                            : {8'h00, bsel_reg ? i_dm_rdata[15:8]
                                               : i_dm_rdata[7:0]};
                    end
                end
                PDT_ST_PROG: begin
                    if (i_pm_ack) begin
                        state_reg   <= PDT_ST_IDLE;
                        o_pm_req    <= 1'b0;
                        o_pm_we     <= 1'b0;
                        o_req_busy  <= 1'b0;
                        o_req_done  <= 1'b1;
                        o_req_rdata <= psv_reg ? i_pm_rdata[15:0]
                                               : steered;
                    end
                end
                default: begin
                    state_reg <= PDT_ST_IDLE;
                end
            endcase
        end
    end

endmodule : pdt_paged_access

/* verification/pdt_checker_sva.sv */
`timescale 1ns/1ps

// ************************************************************
// port-level timing and address checks
// ************************************************************
module pdt_checker
    import pdt_pkg::*;
(
    input wire logic        i_clock,       // clock
    input wire logic        i_reset,       // async reset
    input wire logic        i_wb_cyc,      // bus cycle
    input wire logic        i_wb_stb,      // strobe
    input wire logic        o_wb_ack,      // acknowledge
    input wire logic        i_req_valid,   // core request
    input wire logic [2:0]  i_req_op,      // operation
    input wire logic        i_req_byte,    // byte mode
    input wire logic [15:0] i_req_ea,      // effective address
    input wire logic        o_req_busy,    // in flight
    input wire logic        o_req_done,    // completion
    input wire logic [15:0] o_req_next_ea, // stepped address
    input wire logic        o_dm_req,      // data request
    input wire logic        o_dm_we,       // data write
    input wire logic [23:0] o_dm_addr,     // data address
    input wire logic        i_dm_ack,      // data ack
    input wire logic        o_pm_req,      // program request
    input wire logic [23:0] o_pm_addr,     // program address
    input wire logic        o_pm_cfg,      // config space
    input wire logic        i_pm_ack       // program ack
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // bus answers one cycle after taking, as a single pulse
    property p_wb_ack;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");

    // a taken request shows a memory request at once
    property p_take;
        i_req_valid && !o_req_busy |=> o_req_busy && (o_dm_req || o_pm_req);
    endproperty
    a_take: assert property (p_take) else $error("request not taken");

    // memory ack ends the transfer with a one-cycle done
    property p_done;
        (o_pm_req && i_pm_ack) || (o_dm_req && i_dm_ack)
            |=> o_req_done && !o_req_busy ##1 !o_req_done;
    endproperty
    a_done: assert property (p_done) else $error("done not pulsed");

    // post-step address: two per program word, one per byte
    property p_step;
        $rose(o_req_busy) |-> o_req_next_ea == $past(i_req_ea) +
            ($past(i_req_byte) ? PDT_BYTE_STEP : PDT_WORD_STEP);
    endproperty
    a_step: assert property (p_step) else $error("bad next address");

    // page bits never disturb the low fifteen address bits
    property p_page_low;
        $rose(o_dm_req) |-> o_dm_addr[14:0] == $past(i_req_ea[14:0]);
    endproperty
    a_page_low: assert property (p_page_low) else $error("low bits");

    // lower half of data space ignores both pages
    property p_base;
        $rose(o_dm_req) && !$past(i_req_ea[15])
            |-> o_dm_addr == {8'h00, $past(i_req_ea)};
    endproperty
    a_base: assert property (p_base) else $error("base address");

    // table ops: word-aligned direct address, config from page bit 7
    property p_table;
        $rose(o_pm_req) && $past(i_req_op) != 3'h0 |->
            o_pm_addr[15:0] == {$past(i_req_ea[15:1]), 1'h0} &&
            o_pm_cfg == o_pm_addr[23];
    endproperty
    a_table: assert property (p_table) else $error("table address");

    // request and address stand until memory answers
    property p_hold;
        o_pm_req && !i_pm_ack |=> o_pm_req && $stable(o_pm_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");

    c_wb: cover property (o_wb_ack);
    c_pm: cover property (o_pm_req && i_pm_ack && o_pm_cfg);
    c_dw: cover property (o_dm_req && i_dm_ack && o_dm_we);
endmodule : pdt_checker

bind pdt_paged_access pdt_checker u_chk (.*);

/* verification/pdt_mem_model.sv */
`timescale 1ns/1ps

// ************************************************************
// program and extended data memory stand-in
// ************************************************************
module pdt_mem_model (
    input  wire logic        i_clock,    // clock
    input  wire logic        i_reset,    // async reset
    input  wire logic [1:0]  i_slow,     // wait cycles before ack
    input  wire logic        i_dm_req,   // data request
    output logic             o_dm_ack,   // data ack pulse
    output logic      [15:0] o_dm_rdata, // data word
    input  wire logic        i_pm_req,   // program request
    output logic             o_pm_ack,   // program ack pulse
    output logic      [23:0] o_pm_rdata  // program word
);
    logic [1:0] dm_cnt_reg;
    logic [1:0] pm_cnt_reg;

    // one-cycle ack after i_slow waits; no re-ack while req drops
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            {o_dm_ack, o_pm_ack, dm_cnt_reg, pm_cnt_reg} <= '0;
        end else begin
            o_dm_ack   <= i_dm_req && !o_dm_ack && dm_cnt_reg == i_slow;
            o_pm_ack   <= i_pm_req && !o_pm_ack && pm_cnt_reg == i_slow;
            dm_cnt_reg <= (i_dm_req && !o_dm_ack && dm_cnt_reg != i_slow) ?
                          dm_cnt_reg + 2'h1 : 2'h0;
            pm_cnt_reg <= (i_pm_req && !o_pm_ack && pm_cnt_reg != i_slow) ?
                          pm_cnt_reg + 2'h1 : 2'h0;
        end
    end

    // data only valid in the ack cycle; inverse elsewhere exposes stale use
    assign o_dm_rdata = o_dm_ack ? 16'h6D4B : 16'h92B4;
    assign o_pm_rdata = o_pm_ack ? 24'hC79A3E : 24'h3865C1;
endmodule : pdt_mem_model

/* verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
    import pdt_pkg::*;
    logic        i_clock, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [7:0]  i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, q;
    logic        i_req_valid, i_req_byte, o_req_busy, o_req_done;
    logic [2:0]  i_req_op, o_pm_be, op, be, xbe;
    logic [15:0] i_req_ea, i_req_wdata, o_req_rdata, o_req_next_ea, ea, rd, xrd;
    logic [15:0] o_dm_wdata, i_dm_rdata;
    logic        o_dm_req, o_dm_we, i_dm_ack, o_pm_req, o_pm_we, o_pm_cfg;
    logic        i_pm_ack, b, pm, xpm;
    logic [23:0] o_dm_addr, o_pm_addr, o_pm_wdata, i_pm_rdata, ad, xad;
    logic [1:0]  o_dm_be, slow;
    int          miscompares, samples_checked, cycles;
    logic [63:0] rows [12];

    pdt_paged_access dut (.*);
    pdt_mem_model u_mem (.i_clock, .i_reset, .i_slow(slow),
        .i_dm_req(o_dm_req), .o_dm_ack(i_dm_ack), .o_dm_rdata(i_dm_rdata),
        .i_pm_req(o_pm_req), .o_pm_ack(i_pm_ack), .o_pm_rdata(i_pm_rdata));

    // ************************************************************
    // clock, watchdog and shared tasks
    // ************************************************************
    initial begin
        i_clock = 1'h0;
        forever #4 i_clock = ~i_clock;
    end

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [3:0] sel, input logic [31:0] d);
        @(posedge i_clock);
        {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'h3, we};
        {i_wb_adr, i_wb_sel, i_wb_dat} <= {adr, sel, d};
        do @(posedge i_clock); while (o_wb_ack !== 1'h1);
        q = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'h0;
    endtask : wb

    // one core request; captures memory side, then waits for done
    task automatic core_op(input logic [2:0] o, input logic bm,
                           input logic [15:0] e);
        @(posedge i_clock);
        {i_req_valid, i_req_op, i_req_byte, i_req_ea} <= {1'h1, o, bm, e};
        i_req_wdata <= 16'h00E1;
        @(posedge i_clock);
        i_req_valid <= 1'h0;
        while (!(o_pm_req | o_dm_req)) @(posedge i_clock);
        {pm, ad, be} = o_pm_req ? {1'h1, o_pm_addr, o_pm_be} :
                                  {1'h0, o_dm_addr, 1'h0, o_dm_be};
        q = o_pm_req ? {o_pm_we, o_pm_cfg, 6'h0, o_pm_wdata}
                     : {o_dm_we, 15'h0, o_dm_wdata};
        while (o_req_done !== 1'h1) @(posedge i_clock);
        rd = o_req_rdata;
    endtask : core_op

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        // op, byte, ea, to program memory, address, enables, read data
        rows = '{{3'h0, 1'h0, 16'h8ABC, 1'h0, 24'h918ABC, 3'h0, 16'h6D4B},
                 {3'h1, 1'h0, 16'hC002, 1'h0, 24'h55C002, 3'h3, 16'h0000},
                 {3'h0, 1'h0, 16'h1234, 1'h0, 24'h001234, 3'h0, 16'h6D4B},
                 {3'h2, 1'h0, 16'h0100, 1'h1, 24'h850100, 3'h0, 16'h9A3E},
                 {3'h2, 1'h1, 16'h0101, 1'h1, 24'h850100, 3'h0, 16'h009A},
                 {3'h2, 1'h1, 16'h0100, 1'h1, 24'h850100, 3'h0, 16'h003E},
                 {3'h3, 1'h0, 16'h0200, 1'h1, 24'h850200, 3'h0, 16'h00C7},
                 {3'h3, 1'h1, 16'h0200, 1'h1, 24'h850200, 3'h0, 16'h00C7},
                 {3'h3, 1'h1, 16'h0201, 1'h1, 24'h850200, 3'h0, 16'h0000},
                 {3'h4, 1'h0, 16'h0300, 1'h1, 24'h850300, 3'h3, 16'h0000},
                 {3'h5, 1'h1, 16'h0301, 1'h1, 24'h850300, 3'h0, 16'h0000},
                 {3'h5, 1'h0, 16'h0302, 1'h1, 24'h850302, 3'h4, 16'h0000}};
        {i_wb_cyc, i_wb_stb, i_wb_we, i_req_valid, i_req_byte} = '0;
        {i_wb_adr, i_wb_sel, i_wb_dat, i_req_op, i_req_ea} = '0;
        {i_req_wdata, slow, miscompares, samples_checked, cycles} = '0;
        i_reset = 1'h1;
        repeat (12) @(posedge i_clock);
        i_reset <= 1'h0;
        // all pages clear after reset, unmapped write dropped
        for (int k = 0; k < 4; k++) begin
            wb(1'h0, 8'(k * 4), 4'hF, 32'h0);
            check("reset value", q, 32'h0);
        end
        wb(1'h1, PDT_OFS_READ_PAGE, 4'h3, 32'hFFFF_FD23);
        wb(1'h1, PDT_OFS_WRITE_PAGE, 4'hF, 32'hFFFF_FFFF);
        wb(1'h1, PDT_OFS_TABLE_PAGE, 4'hF, 32'h0000_0085);
        wb(1'h1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        wb(1'h0, PDT_OFS_READ_PAGE, 4'hF, 32'h0);
        check("read page", q, 32'h0000_0123);
        wb(1'h0, PDT_OFS_WRITE_PAGE, 4'hF, 32'h0);
        check("write page width", q, 32'h0000_01FF);
        wb(1'h0, 8'h10, 4'hF, 32'h0);
        check("unmapped", q, 32'h0);
        wb(1'h1, PDT_OFS_WRITE_PAGE, 4'h1, 32'h0000_00AB);
        wb(1'h1, PDT_OFS_WRITE_PAGE, 4'h2, 32'h0000_0000);
        $display("register test done");
        // table of ordinary transfers, memory alternately slow
        for (int i = 0; i < 12; i++) begin
            {op, b, ea, xpm, xad, xbe, xrd} = rows[i];
            slow <= i[0] ? 2'h3 : 2'h0;
            core_op(op, b, ea);
            check("memory side", {31'h0, pm}, {31'h0, xpm});
            check("address", {8'h0, ad}, {8'h0, xad});
            if (op == 3'h1 || op >= 3'h4) begin
                check("enables", {29'h0, be}, {29'h0, xbe});
                check("wdata", q & 32'hBFFF_FFFF,
                      op == 3'h5 ? 32'h80E1_0000 : 32'h8000_00E1);
            end else
                check("read data", {16'h0, rd}, {16'h0, xrd});
        end
        $display("transfer table done");
        // read page bit 9 set turns an upper read into program access
        wb(1'h1, PDT_OFS_READ_PAGE, 4'h2, 32'h0000_0200);
        core_op(3'h0, 1'h0, 16'h8010);
        check("visibility address", {8'h0, ad}, 32'h0023_0020);
        check("visibility data", {16'h0, rd}, 32'h0000_9A3E);
        $display("visibility test done");
        // reset in mid-run clears the pages again
        i_reset <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'h0;
        wb(1'h0, PDT_OFS_READ_PAGE, 4'hF, 32'h0);
        check("page after reset", q, 32'h0);
        core_op(3'h2, 1'h0, 16'h0400);
        check("user space", {q[30], ad}, 32'h0000_0400);
        $display("second reset test done");
        stop_test();
    end
endmodule : testbench
